//--- cmd_mode_defs.vh
// Constants for the serial command mode entry and exit block.
`ifndef CMD_MODE_DEFS_VH
`define CMD_MODE_DEFS_VH

// ----------------------------------------------------------------
// Trigger source codes
// ----------------------------------------------------------------
`define TRIG_OFF        2'h0
`define TRIG_PIN        2'h1
`define TRIG_CHAR       2'h2
`define TRIG_RESET_SEL  2'h1

// ----------------------------------------------------------------
// Characters
// ----------------------------------------------------------------
`define CH_LT           8'h3C
`define CH_GT           8'h3E
`define CH_E            8'h45
`define CH_Y            8'h59
`define CH_3            8'h33
`define CH_CR           8'h0D
`define CH_LF           8'h0A
`define CH_W            8'h57
`define CH_R            8'h52
`define CH_B            8'h42
`define CH_1            8'h31
`define CH_2            8'h32

// ----------------------------------------------------------------
// Timing: clock in hertz, limits in milliseconds and seconds
// ----------------------------------------------------------------
`define CLK_HZ          20000000
`define PIN_HOLD_MS     200
`define GAP_MAX_MS      80
`define IDLE_S          300
`define MS_CYCLES       (`CLK_HZ / 1000)

`endif

//--- ms_tick.v
// Millisecond time base divider.
`timescale 1ns/1ps
`default_nettype none
`include "cmd_mode_defs.vh"
module ms_tick #(
    parameter integer DIV = `MS_CYCLES
) (
    input  wire clk,
    input  wire rstn,
    output reg  tick
);
    reg [31:0] cnt_reg;

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_reg <= 32'h0000_0000;
            tick    <= 1'b0;
        end else if (cnt_reg == DIV - 1) begin
            cnt_reg <= 32'h0000_0000;
            tick    <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + 32'h0000_0001;
            tick    <= 1'b0;
        end
    end
endmodule
`default_nettype wire

//--- cmd_mode_ctrl.v
// Serial command mode entry, reply and exit control.
`timescale 1ns/1ps
`default_nettype none
`include "cmd_mode_defs.vh"
module cmd_mode_ctrl #(
    parameter integer MS_DIV       = `MS_CYCLES,
    parameter integer PIN_HOLD_MS  = `PIN_HOLD_MS,
    parameter integer GAP_MAX_MS   = `GAP_MAX_MS,
    parameter integer IDLE_MS      = `IDLE_S * 1000
) (
    input  wire       clk,
    input  wire       rstn,
    input  wire [1:0] cfg_trig_sel,
    input  wire [23:0] cfg_trig_chars,
    input  wire       cfg_valid,
    input  wire       trigger_input_pin,
    input  wire [7:0] rx_data,
    input  wire       rx_valid,
    input  wire       tx_ready,
    input  wire       cmd_done,
    input  wire       cmd_ok,
    input  wire [15:0] cmd_opcode,
    output reg  [7:0] tx_data,
    output reg        tx_valid,
    output reg  [7:0] fwd_data,
    output reg        fwd_valid,
    output reg  [7:0] cmd_data,
    output reg        cmd_valid,
    output reg        cmd_mode,
    output reg        data_enable,
    output reg        tcp_close_all,
    output reg        tcp_refuse,
    output reg        udp_disable,
    output reg        cfg_save,
    output reg        restart
);
    // ------------------------------------------------------------
    // Main states and reply kinds
    // ------------------------------------------------------------
    localparam [1:0] ST_DATA = 2'h0;
    localparam [1:0] ST_CMD  = 2'h1;
    localparam [1:0] ST_EXIT = 2'h2;
    localparam [1:0] RP_E    = 2'h0;
    localparam [1:0] RP_ERR  = 2'h1;
    localparam [1:0] RP_OK   = 2'h2;

    wire       tick;
    reg  [1:0] state_reg;
    reg  [1:0] trig_sel_reg;
    reg [23:0] trig_chars_reg;
    reg [15:0] hold_reg;
    reg [15:0] gap_reg;
    reg [1:0]  match_reg;
    reg [23:0] pend_reg;
    reg [1:0]  pend_cnt_reg;
    reg        flush_reg;
    reg [31:0] idle_reg;
    reg [2:0]  tx_idx_reg;
    reg [2:0]  tx_len_reg;
    reg [1:0]  rp_kind_reg;
    reg        tx_busy_reg;
    reg        last_cr_reg;
    reg [2:0]  line_len_reg;
    reg [7:0]  line_reg [0:4];
    reg        save_pend_reg;
    reg        exit_pend_reg;
    integer    i;

    ms_tick #(.DIV(MS_DIV)) u_tick (
        .clk  (clk),
        .rstn (rstn),
        .tick (tick)
    );

    // Byte k of the trigger sequence, first character in the high byte.
    function [7:0] trig_byte;
        input [23:0] chars;
        input [1:0]  k;
        begin
            case (k)
                2'h0:    trig_byte = chars[23:16];
                2'h1:    trig_byte = chars[15:8];
                default: trig_byte = chars[7:0];
            endcase
        end
    endfunction

    // Oldest held data byte, the newest one kept in the low byte.
    function [7:0] held_byte;
        input [23:0] held;
        input [1:0]  cnt;
        begin
            case (cnt)
                2'h3:    held_byte = held[23:16];
                2'h2:    held_byte = held[15:8];
                default: held_byte = held[7:0];
            endcase
        end
    endfunction

    // Reply byte at index n for the current reply kind.
    function [7:0] reply_byte;
        input [1:0]  kind;
        input [2:0]  n;
        input [15:0] op;
        begin
            case (n)
                3'h0:    reply_byte = `CH_LT;
                3'h1:    reply_byte = (kind == RP_E) ? `CH_E : ((kind == RP_ERR) ? `CH_3 : `CH_Y);
                3'h2:    reply_byte = (kind == RP_OK) ? op[15:8] : `CH_CR;
                3'h3:    reply_byte = op[7:0];
                default: reply_byte = `CH_CR;
            endcase
        end
    endfunction

    // ------------------------------------------------------------
    // Mode control
    // ------------------------------------------------------------
    // The trigger setting is loaded on any cycle with cfg_valid high, so a
    // change takes hold at once, without a restart.
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_reg      <= ST_DATA;
            trig_sel_reg   <= `TRIG_RESET_SEL;
            trig_chars_reg <= 24'h000000;
            hold_reg       <= 16'h0000;
            gap_reg        <= 16'h0000;
            match_reg      <= 2'h0;
            pend_reg       <= 24'h000000;
            pend_cnt_reg   <= 2'h0;
            flush_reg      <= 1'b0;
            idle_reg       <= 32'h0000_0000;
            tx_idx_reg     <= 3'h0;
            tx_len_reg     <= 3'h0;
            rp_kind_reg    <= RP_E;
            tx_busy_reg    <= 1'b0;
            last_cr_reg    <= 1'b0;
            line_len_reg   <= 3'h0;
            save_pend_reg  <= 1'b0;
            exit_pend_reg  <= 1'b0;
            tx_data        <= 8'h00;
            tx_valid       <= 1'b0;
            fwd_data       <= 8'h00;
            fwd_valid      <= 1'b0;
            cmd_data       <= 8'h00;
            cmd_valid      <= 1'b0;
            cmd_mode       <= 1'b0;
            data_enable    <= 1'b0;
            tcp_close_all  <= 1'b0;
            tcp_refuse     <= 1'b0;
            udp_disable    <= 1'b0;
            cfg_save       <= 1'b0;
            restart        <= 1'b0;
            for (i = 0; i < 5; i = i + 1) begin
                line_reg[i] <= 8'h00;
            end
        end else begin
            fwd_valid     <= 1'b0;
            cmd_valid     <= 1'b0;
            tcp_close_all <= 1'b0;
            cfg_save      <= 1'b0;
            restart       <= 1'b0;
            if (cfg_valid) begin
                trig_sel_reg   <= (cfg_trig_sel == 2'h3) ? `TRIG_OFF : cfg_trig_sel;
                trig_chars_reg <= cfg_trig_chars;
            end
            if (tx_valid && tx_ready) begin
                tx_valid <= 1'b0;
            end
            if (tx_busy_reg && !(tx_valid && !tx_ready)) begin
                tx_data    <= reply_byte(rp_kind_reg, tx_idx_reg, cmd_opcode);
                tx_valid   <= 1'b1;
                tx_idx_reg <= tx_idx_reg + 3'h1;
                if (tx_idx_reg + 3'h1 == tx_len_reg) begin
                    tx_busy_reg <= 1'b0;
                end
            end
            case (state_reg)
                ST_DATA: begin
                    data_enable <= 1'b1;
                    // The first tick may follow the edge at once, so one tick more than the
                    // hold time is counted before entry.
                    if (trig_sel_reg == `TRIG_PIN && tick) begin
                        if (trigger_input_pin) begin
                            hold_reg <= 16'h0000;
                        end else if (hold_reg <= PIN_HOLD_MS[15:0]) begin
                            hold_reg <= hold_reg + 16'h0001;
                        end
                    end
                    if (tick && gap_reg != 16'hFFFF) begin
                        gap_reg <= gap_reg + 16'h0001;
                    end
                    if (pend_cnt_reg != 2'h0 && (flush_reg || gap_reg > GAP_MAX_MS[15:0])) begin
                        // A byte that arrives while held bytes drain is lost; the drain is three cycles at most.
                        match_reg    <= 2'h0;
                        flush_reg    <= (pend_cnt_reg != 2'h1);
                        pend_cnt_reg <= pend_cnt_reg - 2'h1;
                        fwd_data     <= held_byte(pend_reg, pend_cnt_reg);
                        fwd_valid    <= 1'b1;
                    end else if (rx_valid) begin
                        gap_reg <= 16'h0000;
                        if (trig_sel_reg == `TRIG_CHAR && rx_data == trig_byte(trig_chars_reg, match_reg)) begin
                            if (match_reg == 2'h2) begin
                                match_reg    <= 2'h0;
                                pend_cnt_reg <= 2'h0;
                                state_reg    <= ST_CMD;
                            end else begin
                                match_reg    <= match_reg + 2'h1;
                                pend_cnt_reg <= pend_cnt_reg + 2'h1;
                                pend_reg     <= {pend_reg[15:0], rx_data};
                            end
                        end else if (match_reg != 2'h0) begin
                            // A wrong byte ends the sequence and queues behind the held ones.
                            match_reg    <= 2'h0;
                            pend_cnt_reg <= pend_cnt_reg + 2'h1;
                            pend_reg     <= {pend_reg[15:0], rx_data};
                            flush_reg    <= 1'b1;
                        end else begin
                            fwd_data  <= rx_data;
                            fwd_valid <= 1'b1;
                        end
                    end
                    if (trig_sel_reg == `TRIG_PIN && hold_reg > PIN_HOLD_MS[15:0]) begin
                        state_reg <= ST_CMD;
                    end
                    if (state_reg != ST_CMD && hold_reg > PIN_HOLD_MS[15:0]) begin
                        hold_reg <= 16'h0000;
                    end
                end
                ST_CMD: begin
                    if (!cmd_mode) begin
                        cmd_mode      <= 1'b1;
                        data_enable   <= 1'b0;
                        tcp_close_all <= 1'b1;
                        tcp_refuse    <= 1'b1;
                        udp_disable   <= 1'b1;
                        rp_kind_reg   <= RP_E;
                        tx_len_reg    <= 3'h3;
                        tx_idx_reg    <= 3'h0;
                        tx_busy_reg   <= 1'b1;
                        idle_reg      <= 32'h0000_0000;
                        line_len_reg  <= 3'h0;
                    end else begin
                        // The timer runs only after the entry cycle has cleared it, so a count
                        // left from an earlier session cannot end this one at once.
                        if (tick) begin
                            idle_reg <= idle_reg + 32'h0000_0001;
                        end
                        if (idle_reg >= IDLE_MS) begin
                            state_reg     <= ST_EXIT;
                            save_pend_reg <= 1'b0;
                        end
                    end
                    if (rx_valid && cmd_mode) begin
                        last_cr_reg <= (rx_data == `CH_CR);
                        if (rx_data == `CH_LF && last_cr_reg) begin
                            line_len_reg <= 3'h0;
                        end else if (rx_data == `CH_CR) begin
                            line_len_reg <= 3'h0;
                            if (line_len_reg == 3'h0) begin
                                rp_kind_reg <= RP_E;
                                tx_len_reg  <= 3'h3;
                                tx_idx_reg  <= 3'h0;
                                tx_busy_reg <= 1'b1;
                            end else if (line_len_reg == 3'h5 && line_reg[0] == `CH_GT && line_reg[1] == `CH_W &&
                                         line_reg[2] == `CH_B && line_reg[3] == `CH_R &&
                                         (line_reg[4] == `CH_1 || line_reg[4] == `CH_2)) begin
                                exit_pend_reg <= 1'b1;
                                save_pend_reg <= (line_reg[4] == `CH_2);
                                idle_reg      <= 32'h0000_0000;
                            end else begin
                                cmd_data  <= rx_data;
                                cmd_valid <= 1'b1;
                            end
                        end else begin
                            if (line_len_reg != 3'h5) begin
                                line_reg[line_len_reg] <= rx_data;
                                line_len_reg           <= line_len_reg + 3'h1;
                            end
                            cmd_data  <= rx_data;
                            cmd_valid <= 1'b1;
                        end
                    end
                    if (cmd_done) begin
                        rp_kind_reg <= cmd_ok ? RP_OK : RP_ERR;
                        tx_len_reg  <= cmd_ok ? 3'h5 : 3'h3;
                        tx_idx_reg  <= 3'h0;
                        tx_busy_reg <= 1'b1;
                        if (cmd_ok) begin
                            idle_reg <= 32'h0000_0000;
                        end
                    end
                    if (exit_pend_reg && !tx_busy_reg && !tx_valid) begin
                        state_reg <= ST_EXIT;
                    end
                end
                ST_EXIT: begin
                    // Restart is a pulse; this block returns itself to data mode in the same cycle.
                    cfg_save      <= save_pend_reg;
                    restart       <= 1'b1;
                    exit_pend_reg <= 1'b0;
                    cmd_mode      <= 1'b0;
                    tcp_refuse    <= 1'b0;
                    udp_disable   <= 1'b0;
                    state_reg     <= ST_DATA;
                end
                default: begin
                    state_reg <= ST_DATA;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

//--- cmd_mode_asserts.sv
// Checker for command mode entry, replies and exit.
`timescale 1ns/1ps
`default_nettype none
module cmd_mode_asserts #(
    parameter integer MS_DIV  = 4,
    parameter integer IDLE_MS = 50
) (
    input wire logic       clk,
    input wire logic       rstn,
    input wire logic       cmd_done,
    input wire logic       cmd_ok,
    input wire logic [7:0] tx_data,
    input wire logic       tx_valid,
    input wire logic       tx_ready,
    input wire logic       fwd_valid,
    input wire logic       cmd_mode,
    input wire logic       data_enable,
    input wire logic       tcp_close_all,
    input wire logic       tcp_refuse,
    input wire logic       udp_disable,
    input wire logic       cfg_save,
    input wire logic       restart
);
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    // The idle limit is far beyond a delay range, so a counter holds it.
    localparam int IDLE_LIM = IDLE_MS * MS_DIV + 2 * MS_DIV + 4;
    logic [31:0] idle_cnt;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) idle_cnt <= '0;
        else if (!cmd_mode || (cmd_done && cmd_ok)) idle_cnt <= '0;
        else idle_cnt <= idle_cnt + 32'd1;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("reply byte changed before it was taken");
    ack_first_a: assert property ($rose(cmd_mode) |-> ##[0:2] (tx_valid && tx_data == 8'h3C))
        else $error("entry acknowledgement missing");
    close_entry_a: assert property ($rose(cmd_mode) |-> tcp_close_all || $past(tcp_close_all))
        else $error("connections not closed on entry");
    data_stop_a: assert property (cmd_mode |-> !data_enable && !fwd_valid)
        else $error("data still flows in command mode");
    refuse_a: assert property (cmd_mode |-> tcp_refuse)
        else $error("connections accepted in command mode");
    udp_off_a: assert property (cmd_mode |-> udp_disable)
        else $error("datagrams enabled in command mode");
    save_restart_a: assert property (cfg_save |-> restart)
        else $error("save without restart");
    restart_exit_a: assert property (restart |=> !restart ##[0:1] !cmd_mode)
        else $error("restart did not leave command mode");
    idle_bound_a: assert property (idle_cnt <= IDLE_LIM)
        else $error("idle command mode outlived its limit");
    cover property ($rose(cmd_mode));
    cover property (restart && cfg_save);
    cover property (restart && !cfg_save);
    cover property (fwd_valid);
endmodule
bind cmd_mode_ctrl cmd_mode_asserts #(.MS_DIV(MS_DIV), .IDLE_MS(IDLE_MS)) cmd_mode_asserts_i (
    .clk, .rstn, .cmd_done, .cmd_ok, .tx_data, .tx_valid, .tx_ready, .fwd_valid, .cmd_mode,
    .data_enable, .tcp_close_all, .tcp_refuse, .udp_disable, .cfg_save, .restart);
`default_nettype wire

//--- serial_host_model.sv
// Serial host on the data port: sends bytes and collects replies.
`timescale 1ns/1ps
`default_nettype none
module serial_host_model (
    input  wire logic       clk,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_valid,
    input  wire logic       slow,
    output var  logic [7:0] rx_data,
    output var  logic       rx_valid,
    output var  logic       tx_ready
);
    logic [7:0] got[$];
    logic [1:0] ph = 2'h0;
    initial begin
        rx_data = 8'h00;
        rx_valid = 1'b0;
        tx_ready = 1'b1;
    end
    // A slow host takes a byte on one cycle in four, so reply bytes leave at most one every four cycles.
    always @(negedge clk) begin
        ph <= ph + 2'h1;
        tx_ready <= !slow || (ph == 2'h3);
    end
    always @(posedge clk) if (tx_valid && tx_ready) got.push_back(tx_data);
    // Between bytes the line shows the inverse, never a stale copy.
    task automatic send(input logic [7:0] b, input int gap);
        @(negedge clk);
        rx_data = b;
        rx_valid = 1'b1;
        @(negedge clk);
        rx_valid = 1'b0;
        rx_data = ~b;
        repeat (gap) @(negedge clk);
    endtask
endmodule
`default_nettype wire

//--- serial_command_mode_entry_exit_tb.sv
// Testbench for the serial command mode entry and exit block.
`timescale 1ns/1ps
`default_nettype none
module serial_command_mode_entry_exit_tb;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic [1:0]  cfg_trig_sel = 2'h1;
    logic [23:0] cfg_trig_chars = 24'h2B2B2B;
    logic        cfg_valid = 1'b0;
    logic        trigger_input_pin = 1'b1;
    logic        cmd_done = 1'b0;
    logic        cmd_ok = 1'b0;
    logic [15:0] cmd_opcode = 16'h4E50;
    logic        slow = 1'b0;
    logic        saw_save = 1'b0;
    logic [7:0]  last_cmd = 8'h00;
    wire  [7:0]  rx_data, tx_data, fwd_data, cmd_data;
    wire         rx_valid, tx_ready, tx_valid, fwd_valid, cmd_valid, cmd_mode, data_enable;
    wire         tcp_close_all, tcp_refuse, udp_disable, cfg_save, restart;
    int          n_errors = 0, num_checks = 0, n_rst = 0, n_fwd = 0, n_cmd = 0, cyc = 0;
    // ----------------------------------------------------------------
    // Instances, clock and monitors
    // ----------------------------------------------------------------
    cmd_mode_ctrl #(.MS_DIV(4), .IDLE_MS(50)) cmd_mode_ctrl_i (
        .clk, .rstn, .cfg_trig_sel, .cfg_trig_chars, .cfg_valid, .trigger_input_pin, .rx_data,
        .rx_valid, .tx_ready, .cmd_done, .cmd_ok, .cmd_opcode, .tx_data, .tx_valid, .fwd_data,
        .fwd_valid, .cmd_data, .cmd_valid, .cmd_mode, .data_enable, .tcp_close_all, .tcp_refuse,
        .udp_disable, .cfg_save, .restart);
    serial_host_model serial_host_model_i (.clk, .tx_data, .tx_valid, .slow, .rx_data, .rx_valid, .tx_ready);
    initial forever #25 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (restart === 1'b1) n_rst <= n_rst + 1;
        if (restart === 1'b1) saw_save <= cfg_save;
        if (fwd_valid === 1'b1) n_fwd <= n_fwd + 1;
        if (cmd_valid === 1'b1) n_cmd <= n_cmd + 1;
        if (cmd_valid === 1'b1) last_cmd <= cmd_data;
        if (fwd_valid === 1'b1) check(fwd_data, 8'h2B, "forwarded byte");
        if (cyc == 20000) begin
            n_errors = n_errors + 1;
            tally_and_finish();
        end
    end
    task automatic check(input logic [39:0] seen, input logic [39:0] exp, input string what);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic reply(input int n, input logic [39:0] exp, input string what);
        logic [39:0] seen;
        int i;
        seen = '0;
        for (i = 0; i < 400 && serial_host_model_i.got.size() < n; i++) @(posedge clk);
        for (i = 0; i < serial_host_model_i.got.size(); i++) seen = {seen[31:0], serial_host_model_i.got[i]};
        serial_host_model_i.got.delete();
        check(seen, exp, what);
    endtask
    task automatic done(input logic ok);
        @(negedge clk);
        cmd_ok = ok;
        cmd_done = 1'b1;
        @(negedge clk);
        cmd_done = 1'b0;
    endtask
    task automatic exit_cmd(input logic [7:0] p);
        int k;
        k = n_cmd;
        serial_host_model_i.send(8'h3E, 1);
        serial_host_model_i.send(8'h57, 1);
        serial_host_model_i.send(8'h42, 1);
        serial_host_model_i.send(8'h52, 1);
        serial_host_model_i.send(p, 1);
        serial_host_model_i.send(8'h0D, 1);
        check({n_cmd - k, last_cmd}, {32'h0000_0005, p}, "command bytes passed on");
    endtask
    task automatic await_restart(input logic save, input string what);
        int k0 = n_rst;
        int i;
        for (i = 0; i < 400 && n_rst == k0; i++) @(negedge clk);
        check({cmd_mode, saw_save, n_rst == k0 + 1}, {1'b0, save, 1'b1}, what);
    endtask
    task automatic enter_pin(input int ms);
        @(negedge clk);
        trigger_input_pin = 1'b0;
        repeat (ms * 4) @(negedge clk);
        trigger_input_pin = 1'b1;
    endtask
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_pin;
        enter_pin(150);
        check(cmd_mode, 1'b0, "entry on a short low");
        repeat (40) @(negedge clk);
        enter_pin(210);
        check(cmd_mode, 1'b1, "pin entry with default source");
        reply(3, 40'h3C450D, "entry ack");
    endtask
    task automatic t_session;
        serial_host_model_i.send(8'h0D, 1);
        reply(3, 40'h3C450D, "probe CR");
        serial_host_model_i.send(8'h0D, 1);
        serial_host_model_i.send(8'h0A, 1);
        reply(3, 40'h3C450D, "probe CRLF");
        done(1'b0);
        reply(3, 40'h3C330D, "error reply");
        slow = 1'b1;
        done(1'b1);
        reply(5, 40'h3C594E500D, "success reply to a slow host");
        exit_cmd(8'h32);
        await_restart(1'b1, "save and restart");
        slow = 1'b0;
    endtask
    task automatic t_idle;
        enter_pin(210);
        reply(3, 40'h3C450D, "second entry ack");
        await_restart(1'b0, "idle restart");
    endtask
    task automatic t_char;
        int k;
        @(negedge clk);
        cfg_trig_sel = 2'h2;
        cfg_valid = 1'b1;
        @(negedge clk);
        cfg_valid = 1'b0;
        enter_pin(210);
        check(cmd_mode, 1'b0, "pin ignored under char source");
        k = n_fwd;
        repeat (3) serial_host_model_i.send(8'h2B, 520);
        check({cmd_mode, n_fwd - k}, {1'b0, 32'd3}, "slow sequence is data");
        repeat (3) serial_host_model_i.send(8'h2B, 40);
        reply(3, 40'h3C450D, "char entry ack");
        exit_cmd(8'h31);
        await_restart(1'b0, "restart without save");
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (5) @(negedge clk);
        rstn = 1'b1;
        @(negedge clk);
        check({cmd_mode, data_enable}, 2'b01, "data mode after reset");
        t_pin;
        t_session;
        t_idle;
        t_char;
        tally_and_finish();
    end
endmodule
`default_nettype wire
